/* rbss_far_model.sv */
// Far side model: system reset source and byte wide boot memory.
`timescale 1ns/1ns
module rbss_far_model #(
	parameter int HOLD = 60
) (
	input  wire logic        clk,
	input  wire logic        cs_o,
	input  wire logic        cs_oe,
	input  wire logic [23:0] addr,
	output logic             rst_pin_n,
	output logic [7:0]       data
);
	int         cnt  = 0;
	logic [7:0] last = 8'h00;
	initial rst_pin_n = 1'b0;
	always @(posedge clk) begin
		cnt <= cnt + 1;
		if (cnt == HOLD) rst_pin_n <= 1'b1;
		last <= data;
	end
	always_comb begin
		if (cs_oe && !cs_o) data = addr[7:0] ^ 8'h5A;
		else data = ~last;
	end
endmodule : rbss_far_model

/* rbss_pkg.sv */
// Register map, field positions, timing counts and types of the reset, boot and sleep sequencer.
package rbss_pkg;

	localparam logic [7:0]  REG_CTRL          = 8'h00;
	localparam logic [7:0]  REG_STAT          = 8'h04;
	localparam logic [7:0]  REG_IRQ_STAT      = 8'h08;
	localparam logic [7:0]  REG_IRQ_CLR       = 8'h0C;
	localparam logic [7:0]  REG_IRQ_EN        = 8'h10;
	localparam logic [7:0]  REG_INT_EN        = 8'h14;

	localparam int          CTRL_CORE_RST     = 0;
	localparam int          CTRL_SLEEP        = 1;
	localparam int          CTRL_LDIV_LSB     = 4;
	localparam int          LDIV_W            = 4;
	localparam logic [3:0]  LDIV_RST          = 4'h1;
	localparam logic [3:0]  INT_EN_RST        = 4'h3;

	localparam int          EV_WAKE           = 0;
	localparam int          EV_BOOT_DONE      = 1;
	localparam int          EV_START          = 2;
	localparam int          EV_SHORT_RST      = 3;
	localparam int          EV_W              = 4;

	localparam int          SYS_CLK_MHZ       = 250;
	localparam int          POR_HOLD_US       = 1000;
	localparam int          POR_HOLD_CYC      = POR_HOLD_US * SYS_CLK_MHZ;
	localparam int          NORM_HOLD_BUS_CYC = 100;
	localparam int          EPROM_WAIT_CYC    = 16;
	localparam int          EPROM_ADDR_W      = 24;
	localparam int          LINK_CHANNELS     = 4;
	localparam logic [15:0] LINK_BLOCK_WORDS  = 16'h0100;
	localparam logic [31:0] LINK_DMA_BASE     = 32'h0000_0000;
	localparam logic [31:0] LINK_VECTOR       = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_EPROM = 5'h02,
		ST_IDLE  = 5'h04,
		ST_RUN   = 5'h08,
		ST_SLEEP = 5'h10
	} rbss_state_t;

	typedef enum logic [1:0] {
		BOOT_EPROM = 2'h0,
		BOOT_HOST  = 2'h1,
		BOOT_LINK  = 2'h2,
		BOOT_NONE  = 2'h3
	} rbss_boot_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
	} rbss_memwr_t;

	typedef struct packed {
		logic [31:0] base;
		logic [15:0] count;
		logic        irq_en;
	} rbss_ldma_t;

	// Core clock ratio in half steps: 2, 2.5, 3, 3.5, 4 and 5.
	function automatic logic [3:0] ratio_half(input logic [2:0] code);
		case (code)
			3'h1: return 4'h5;
			3'h2: return 4'h6;
			3'h3: return 4'h7;
			3'h4: return 4'h8;
			3'h5: return 4'hA;
			default: return 4'h4;
		endcase
	endfunction : ratio_half

	function automatic rbss_boot_t boot_decode(input logic strap_high, input logic [1:0] src);
		if (!strap_high) return BOOT_EPROM;
		else if (src == 2'h0) return BOOT_HOST;
		else if (src == 2'h1) return BOOT_LINK;
		else return BOOT_NONE;
	endfunction : boot_decode

endpackage : rbss_pkg

/* rbss_sequencer.sv */
// Reset, boot selection, sleep and clock-enable sequencer with an AXI4-Lite register slave.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rbss_sequencer import rbss_pkg::*; #(
	parameter int          POR_HOLD_CYCLES = POR_HOLD_CYC,
	parameter int          BOOT_WORDS      = 256,
	parameter logic [31:0] EXT_START_ADDR  = 32'h8000_0000,
	parameter logic [31:0] IRQ_VEC_BASE    = 32'h0000_0040
) (
	input  wire logic                         SYS_CLK,
	input  wire logic                         RESET_N,
	input  wire logic [7:0]                   S_AXI_AWADDR,
	input  wire logic                         S_AXI_AWVALID,
	output logic                              S_AXI_AWREADY,
	input  wire logic [31:0]                  S_AXI_WDATA,
	input  wire logic [3:0]                   S_AXI_WSTRB,
	input  wire logic                         S_AXI_WVALID,
	output logic                              S_AXI_WREADY,
	output logic [1:0]                        S_AXI_BRESP,
	output logic                              S_AXI_BVALID,
	input  wire logic                         S_AXI_BREADY,
	input  wire logic [7:0]                   S_AXI_ARADDR,
	input  wire logic                         S_AXI_ARVALID,
	output logic                              S_AXI_ARREADY,
	output logic [31:0]                       S_AXI_RDATA,
	output logic [1:0]                        S_AXI_RRESP,
	output logic                              S_AXI_RVALID,
	input  wire logic                         S_AXI_RREADY,
	input  wire logic                         EXT_RESET_N_PIN,
	input  wire logic [3:0]                   IRQ_N_PIN,
	input  wire logic                         BOOT_SELECT_STRAP_I,
	output logic                              BOOT_SELECT_STRAP_O,
	output logic                              BOOT_SELECT_STRAP_OE,
	input  wire logic [1:0]                   BOOT_SRC_PINS,
	input  wire logic [2:0]                   CORE_CLOCK_RATIO_PINS,
	output logic [EPROM_ADDR_W-1:0]           EPROM_ADDR,
	input  wire logic [7:0]                   EPROM_DATA,
	input  wire rbss_memwr_t                  HOST_WR,
	output logic                              HOST_WR_READY,
	input  wire logic [LINK_CHANNELS-1:0]     LINK_BLOCK_DONE,
	output rbss_memwr_t                       MEM_WR,
	output rbss_ldma_t [LINK_CHANNELS-1:0]    LINK_DMA_PRESET,
	output logic [1:0]                        BOOT_MODE,
	output logic                              BUS_RESET_N,
	output logic                              CORE_RESET_N,
	output logic                              CORE_RUN,
	output logic                              CORE_START,
	output logic [31:0]                       CORE_VECTOR,
	output logic                              BUS_CLK_EN,
	output logic                              LINK_CLK_EN,
	output logic                              IRQ
);
	localparam int WCW = $clog2(BOOT_WORDS) + 1;
	localparam int RCW = $clog2(POR_HOLD_CYCLES + 1);

	function automatic logic [31:0] irq_vector(input logic [3:0] hit);
		logic [31:0] v;
		v = IRQ_VEC_BASE;
		for (int i = 3; i >= 0; i--) begin
			if (hit[i]) v = IRQ_VEC_BASE + 32'(i * 4);
		end
		return v;
	endfunction : irq_vector

	////////////////////////////////////////////////////////////////////////////////////////////////////
	logic [18:0] pins_s;
	logic        ext_ok;
	logic [3:0]  irq_s;
	logic        boot_sel_s;
	logic [1:0]  boot_src_s;
	logic [2:0]  ratio_s;
	logic [7:0]  eprom_data_s;

	rbss_sync3 #(.W(19), .RST_VAL(19'h3_C000)) u_pin_sync (
		.clk   (SYS_CLK),
		.rst_n (RESET_N),
		.d     ({EXT_RESET_N_PIN, IRQ_N_PIN, BOOT_SELECT_STRAP_I, BOOT_SRC_PINS, CORE_CLOCK_RATIO_PINS, EPROM_DATA}),
		.q     (pins_s)
	);
	assign ext_ok       = pins_s[18];
	assign irq_s        = pins_s[17:14];
	assign boot_sel_s   = pins_s[13];
	assign boot_src_s   = pins_s[12:11];
	assign ratio_s      = pins_s[10:8];
	assign eprom_data_s = pins_s[7:0];

	////////////////////////////////////////////////////////////////////////////////////////////////////
	rbss_state_t             state_r, state_nxt;
	rbss_boot_t              boot_mode_r, boot_mode_nxt;
	logic [2:0]              ratio_r, ratio_nxt;
	logic [4:0]              wait_r, wait_nxt;
	logic [1:0]              byte_r, byte_nxt;
	logic [31:0]             sh_r, sh_nxt;
	logic [EPROM_ADDR_W-1:0] rom_addr_r, rom_addr_nxt;
	logic [WCW-1:0]          wcnt_r, wcnt_nxt;
	rbss_memwr_t             mem_r, mem_nxt;
	logic                    start_r, start_nxt;
	logic [31:0]             vec_r, vec_nxt;
	logic [3:0]              irq_d_r;
	logic [3:0]              irq_fall, irq_fall_en;
	logic [EV_W-1:0]         ev_seq, ev_all;
	logic                    byte_take, sleep_go, core_rst_r;
	logic [3:0]              int_en_r;

	assign irq_fall    = irq_d_r & ~irq_s;
	assign irq_fall_en = irq_fall & int_en_r;

	always_comb begin
		state_nxt = state_r; boot_mode_nxt = boot_mode_r; ratio_nxt = ratio_r; wait_nxt = wait_r;
		byte_nxt = byte_r; sh_nxt = sh_r; rom_addr_nxt = rom_addr_r; wcnt_nxt = wcnt_r;
		mem_nxt = mem_r; mem_nxt.valid = 1'b0; start_nxt = 1'b0; vec_nxt = vec_r;
		ev_seq = '0; byte_take = 1'b0;
		if (!ext_ok) begin
			state_nxt = ST_RESET;
		end else begin
			case (state_r)
				ST_RESET: begin
					ratio_nxt     = ratio_s;
					boot_mode_nxt = boot_decode(boot_sel_s, boot_src_s);
					wait_nxt = '0; byte_nxt = '0; rom_addr_nxt = '0; wcnt_nxt = '0;
					state_nxt = boot_sel_s ? ST_IDLE : ST_EPROM;
				end
				ST_EPROM: begin
					if (wait_r == 5'(EPROM_WAIT_CYC)) begin
						byte_take    = 1'b1;
						wait_nxt     = '0;
						sh_nxt       = {eprom_data_s, sh_r[31:8]};
						rom_addr_nxt = rom_addr_r + 1'b1;
						byte_nxt     = byte_r + 1'b1;
						if (byte_r == 2'h3) begin
							mem_nxt = '{valid: 1'b1, addr: 32'(wcnt_r), data: {eprom_data_s, sh_r[31:8]}};
							wcnt_nxt = wcnt_r + 1'b1;
							if (wcnt_r == WCW'(BOOT_WORDS - 1)) begin
								state_nxt            = ST_IDLE;
								ev_seq[EV_BOOT_DONE] = 1'b1;
							end
						end
					end else begin
						wait_nxt = wait_r + 1'b1;
					end
				end
				ST_IDLE: begin
					if (!core_rst_r && boot_mode_r == BOOT_LINK && |LINK_BLOCK_DONE) begin
						state_nxt = ST_RUN; start_nxt = 1'b1; vec_nxt = LINK_VECTOR;
						ev_seq[EV_START] = 1'b1;
					end else if (!core_rst_r && |irq_fall_en) begin
						state_nxt = ST_RUN; start_nxt = 1'b1; ev_seq[EV_START] = 1'b1;
						vec_nxt = (boot_mode_r == BOOT_NONE) ? EXT_START_ADDR : irq_vector(irq_fall_en);
					end
				end
				ST_RUN: begin
					if (core_rst_r) state_nxt = ST_IDLE;
					else if (sleep_go) state_nxt = ST_SLEEP;
				end
				ST_SLEEP: begin
					if (core_rst_r) begin
						state_nxt = ST_IDLE;
					end else if (|irq_fall) begin
						state_nxt = ST_RUN; ev_seq[EV_WAKE] = 1'b1;
						if (|irq_fall_en) begin
							start_nxt = 1'b1; vec_nxt = irq_vector(irq_fall_en);
						end
					end
				end
				default: state_nxt = ST_RESET;
			endcase
		end
		if (!mem_nxt.valid && HOST_WR.valid && HOST_WR_READY) mem_nxt = HOST_WR;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			state_r <= ST_RESET; boot_mode_r <= BOOT_EPROM; ratio_r <= 3'h0; wait_r <= 5'h00;
			byte_r <= 2'h0; sh_r <= 32'h0; rom_addr_r <= '0; wcnt_r <= '0; mem_r <= '0;
			start_r <= 1'b0; vec_r <= 32'h0; irq_d_r <= 4'hF;
		end else begin
			state_r <= state_nxt; boot_mode_r <= boot_mode_nxt; ratio_r <= ratio_nxt; wait_r <= wait_nxt;
			byte_r <= byte_nxt; sh_r <= sh_nxt; rom_addr_r <= rom_addr_nxt; wcnt_r <= wcnt_nxt;
			mem_r <= mem_nxt; start_r <= start_nxt; vec_r <= vec_nxt; irq_d_r <= irq_s;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N || !ext_ok) begin
			for (int i = 0; i < LINK_CHANNELS; i++) begin
				LINK_DMA_PRESET[i] <= '{base: LINK_DMA_BASE, count: LINK_BLOCK_WORDS, irq_en: 1'b1};
			end
		end
	end

	assign HOST_WR_READY        = ext_ok && state_r != ST_RESET && !(state_r == ST_EPROM && byte_take);
	assign MEM_WR               = mem_r;
	assign EPROM_ADDR           = rom_addr_r;
	assign BOOT_MODE            = boot_mode_r;
	assign CORE_RUN             = state_r == ST_RUN;
	assign CORE_START           = start_r;
	assign CORE_VECTOR          = vec_r;
	assign BOOT_SELECT_STRAP_O  = 1'b0;
	assign BOOT_SELECT_STRAP_OE = state_r == ST_EPROM;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	logic [3:0]     acc_r, acc_nxt;
	logic [4:0]     acc_sum;
	logic           bus_en_r, bus_en_nxt, link_en_r, link_en_nxt;
	logic [3:0]     ldiv_r, lcnt_r, lcnt_nxt;
	logic [RCW-1:0] rcnt_r, rcnt_nxt;
	logic [6:0]     bcnt_r, bcnt_nxt;
	logic           por_done_r, por_done_nxt, ext_d_r, short_ev;
	logic           bus_rn_r, core_rn_r;

	always_comb begin
		acc_sum = {1'b0, acc_r} + 5'h02;
		if (acc_sum >= {1'b0, ratio_half(ratio_r)}) begin
			acc_nxt = 4'(acc_sum - {1'b0, ratio_half(ratio_r)}); bus_en_nxt = 1'b1;
		end else begin
			acc_nxt = acc_sum[3:0]; bus_en_nxt = 1'b0;
		end
		if (lcnt_r >= ldiv_r) begin
			lcnt_nxt = 4'h0; link_en_nxt = 1'b1;
		end else begin
			lcnt_nxt = lcnt_r + 1'b1; link_en_nxt = 1'b0;
		end
		rcnt_nxt = rcnt_r; bcnt_nxt = bcnt_r; por_done_nxt = por_done_r; short_ev = 1'b0;
		if (!ext_ok) begin
			if (rcnt_r != '1) rcnt_nxt = rcnt_r + 1'b1;
			if (bus_en_r && bcnt_r != 7'h7F) bcnt_nxt = bcnt_r + 1'b1;
		end else if (!ext_d_r) begin
			short_ev = por_done_r ? (bcnt_r < 7'(NORM_HOLD_BUS_CYC))
				: (rcnt_r < RCW'(POR_HOLD_CYCLES));
			por_done_nxt = 1'b1; rcnt_nxt = '0; bcnt_nxt = '0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			acc_r <= 4'h0; bus_en_r <= 1'b0; lcnt_r <= 4'h0; link_en_r <= 1'b0; rcnt_r <= '0; bcnt_r <= 7'h00;
			por_done_r <= 1'b0; ext_d_r <= 1'b0; bus_rn_r <= 1'b0; core_rn_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt; bus_en_r <= bus_en_nxt; lcnt_r <= lcnt_nxt; link_en_r <= link_en_nxt;
			rcnt_r <= rcnt_nxt; bcnt_r <= bcnt_nxt; por_done_r <= por_done_nxt; ext_d_r <= ext_ok;
			bus_rn_r <= ext_ok;
			core_rn_r <= ext_ok && !core_rst_r;
		end
	end

	assign BUS_CLK_EN   = bus_en_r;
	assign LINK_CLK_EN  = link_en_r;
	assign BUS_RESET_N  = bus_rn_r;
	assign CORE_RESET_N = core_rn_r;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	logic            aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bval_r, bval_nxt, rval_r, rval_nxt;
	logic [7:0]      awa_r, awa_nxt;
	logic [31:0]     wd_r, wd_nxt, rd_r, rd_nxt;
	logic            ws_r, ws_nxt;
	logic [1:0]      bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic            core_rst_nxt;
	logic [3:0]      ldiv_nxt, int_en_nxt;
	logic [EV_W-1:0] stat_r, stat_nxt, en_r, en_nxt, clr;
	logic            irq_r;

	assign S_AXI_AWREADY = !aw_ok_r && !bval_r;
	assign S_AXI_WREADY  = !w_ok_r && !bval_r;
	assign S_AXI_ARREADY = !rval_r;
	assign ev_all        = ev_seq | (EV_W'(short_ev) << EV_SHORT_RST);

	always_comb begin
		aw_ok_nxt = aw_ok_r; w_ok_nxt = w_ok_r; awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
		bval_nxt = bval_r; bresp_nxt = bresp_r; rval_nxt = rval_r; rd_nxt = rd_r; rresp_nxt = rresp_r;
		core_rst_nxt = core_rst_r; ldiv_nxt = ldiv_r; int_en_nxt = int_en_r; en_nxt = en_r;
		clr = '0; sleep_go = 1'b0;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_ok_nxt = 1'b1; awa_nxt = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_ok_nxt = 1'b1; wd_nxt = S_AXI_WDATA; ws_nxt = S_AXI_WSTRB[0];
		end
		if (aw_ok_r && w_ok_r) begin
			aw_ok_nxt = 1'b0; w_ok_nxt = 1'b0; bval_nxt = 1'b1; bresp_nxt = RESP_OKAY;
			if (awa_r == REG_CTRL) begin
				if (ws_r) begin
					core_rst_nxt = wd_r[CTRL_CORE_RST];
					sleep_go     = wd_r[CTRL_SLEEP];
					ldiv_nxt     = wd_r[CTRL_LDIV_LSB +: LDIV_W];
				end
			end else if (awa_r == REG_IRQ_CLR) begin
				if (ws_r) clr = wd_r[EV_W-1:0];
			end else if (awa_r == REG_IRQ_EN) begin
				if (ws_r) en_nxt = wd_r[EV_W-1:0];
			end else if (awa_r == REG_INT_EN) begin
				if (ws_r) int_en_nxt = wd_r[3:0];
			end else if (awa_r != REG_STAT && awa_r != REG_IRQ_STAT) begin
				bresp_nxt = RESP_SLVERR;
			end
		end else if (bval_r && S_AXI_BREADY) begin
			bval_nxt = 1'b0;
		end
		if (S_AXI_ARVALID && !rval_r) begin
			rval_nxt = 1'b1; rresp_nxt = RESP_OKAY; rd_nxt = 32'h0000_0000;
			if (S_AXI_ARADDR == REG_CTRL) rd_nxt = 32'({ldiv_r, 3'h0, core_rst_r});
			else if (S_AXI_ARADDR == REG_STAT) rd_nxt = 32'({ratio_r, boot_mode_r, 3'h0, state_r});
			else if (S_AXI_ARADDR == REG_IRQ_STAT) rd_nxt = 32'(stat_r);
			else if (S_AXI_ARADDR == REG_IRQ_EN) rd_nxt = 32'(en_r);
			else if (S_AXI_ARADDR == REG_INT_EN) rd_nxt = 32'(int_en_r);
			else if (S_AXI_ARADDR != REG_IRQ_CLR) rresp_nxt = RESP_SLVERR;
		end else if (rval_r && S_AXI_RREADY) begin
			rval_nxt = 1'b0;
		end
		stat_nxt = (stat_r & ~clr) | ev_all;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			aw_ok_r <= 1'b0; w_ok_r <= 1'b0; awa_r <= 8'h00; wd_r <= 32'h0; ws_r <= 1'b0; bval_r <= 1'b0;
			bresp_r <= 2'h0; rval_r <= 1'b0; rd_r <= 32'h0; rresp_r <= 2'h0; core_rst_r <= 1'b0;
			ldiv_r <= LDIV_RST; int_en_r <= INT_EN_RST; en_r <= '0; stat_r <= '0; irq_r <= 1'b0;
		end else begin
			aw_ok_r <= aw_ok_nxt; w_ok_r <= w_ok_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
			bval_r <= bval_nxt; bresp_r <= bresp_nxt; rval_r <= rval_nxt; rd_r <= rd_nxt; rresp_r <= rresp_nxt;
			core_rst_r <= core_rst_nxt; ldiv_r <= ldiv_nxt; int_en_r <= int_en_nxt; en_r <= en_nxt;
			stat_r <= stat_nxt; irq_r <= |(stat_nxt & en_nxt);
		end
	end

	assign S_AXI_BVALID = bval_r;
	assign S_AXI_BRESP  = bresp_r;
	assign S_AXI_RVALID = rval_r;
	assign S_AXI_RDATA  = rd_r;
	assign S_AXI_RRESP  = rresp_r;
	assign IRQ          = irq_r;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	AST_CORE_ONLY: assert property (ext_ok && core_rst_r |=> !CORE_RESET_N && BUS_RESET_N)
		else $error("core reset disturbed bus side");
	AST_EPROM_DEFAULT: assert property (state_r == ST_RESET && ext_ok && !boot_sel_s
		|=> boot_mode_r == BOOT_EPROM && state_r == ST_EPROM) else $error("eprom boot not chosen");
	AST_HOST_ACCEPT: assert property (ext_ok && state_r == ST_IDLE && HOST_WR.valid && !start_r
		|=> MEM_WR.valid && MEM_WR.data == $past(HOST_WR.data)) else $error("host write dropped");
	AST_LINK_PRESET: assert property ($rose(ext_ok) |-> LINK_DMA_PRESET[2].count == LINK_BLOCK_WORDS
		&& LINK_DMA_PRESET[0].base == LINK_DMA_BASE && LINK_DMA_PRESET[3].irq_en) else $error("link preset wrong");
	AST_LINK_VECTOR: assert property (ext_ok && state_r == ST_IDLE && boot_mode_r == BOOT_LINK
		&& !core_rst_r && |LINK_BLOCK_DONE |=> CORE_START && CORE_VECTOR == 32'h0) else $error("link vector");
	AST_NOBOOT_START: assert property (ext_ok && state_r == ST_IDLE && boot_mode_r == BOOT_NONE
		&& !core_rst_r && irq_fall_en == 4'h0 |=> !CORE_RUN && !CORE_START) else $error("started without irq");
	AST_IDLE_EXIT: assert property (state_r == ST_RESET && ext_ok && boot_sel_s
		|=> state_r == ST_IDLE && !CORE_START) else $error("reset exit not idle");
	AST_SLEEP_WAKE: assert property (ext_ok && state_r == ST_SLEEP && !core_rst_r && |irq_fall
		|=> CORE_RUN && stat_r[EV_WAKE]) else $error("no wake on falling edge");
	AST_WAKE_MASKED: assert property (state_r == ST_SLEEP && irq_fall_en == 4'h0 |=> !CORE_START)
		else $error("service of disabled interrupt");
	AST_BUS_HALF: assert property (BUS_CLK_EN |=> !BUS_CLK_EN) else $error("bus rate above half");
	AST_RATIO_FIVE: assert property (BUS_CLK_EN && ratio_r == 3'h5 |=> !BUS_CLK_EN [*4] ##1 BUS_CLK_EN)
		else $error("ratio five period wrong");
	AST_LINK_DIV: assert property (LINK_CLK_EN && ldiv_r == 4'h2 && !(aw_ok_r && w_ok_r)
		|=> !LINK_CLK_EN ##1 !LINK_CLK_EN ##1 (LINK_CLK_EN || ldiv_r != 4'h2)) else $error("link divisor");
	AST_BOOT_CS: assert property (state_r == ST_EPROM |-> BOOT_SELECT_STRAP_OE && !BOOT_SELECT_STRAP_O)
		else $error("boot select not driven");
	AST_EPROM_WAIT: assert property (disable iff (!RESET_N || !ext_ok) byte_take && state_nxt == ST_EPROM
		|=> !byte_take [*8] ##1 !byte_take [*8] ##1 byte_take) else $error("eprom wait count");

	COV_EPROM_DONE: cover property (ev_seq[EV_BOOT_DONE]);
	COV_SLEEP_WAKE: cover property (state_r == ST_SLEEP ##1 state_r == ST_RUN);
	COV_LINK_BOOT: cover property (boot_mode_r == BOOT_LINK && CORE_START);
	COV_CORE_RESET: cover property (state_r == ST_RUN && core_rst_r ##1 state_r == ST_IDLE);

endmodule : rbss_sequencer

/* rbss_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module rbss_sync3 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= q_nxt;
		end
	end
endmodule : rbss_sync3

/* test_rbss_sequencer.sv */
// Self checking testbench of the reset, boot and sleep sequencer.
`timescale 1ns/1ns
module test_rbss_sequencer import rbss_pkg::*;;
	localparam logic [31:0] VEC = 32'h0000_0040;
	logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, t;
	logic [7:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rd, seed = 32'hAAF50D26;
	logic [3:0]  irq_n = 4'hF;
	logic [2:0]  ratio = 3'h0;
	logic [1:0]  resp;
	logic [1:0]  src = 2'h0;
	logic [3:0]  ldone = 4'h0;
	logic        strap = 1'b0;
	rbss_memwr_t host = '0, e;
	rbss_memwr_t exp_q[$];
	int          errors = 0, n_tests = 0, cyc = 0, starts = 0, links = 0, buses = 0, l0;
	wire logic awr, wr, bv, arr, rv, so, soe, ext_n, hrdy, brn, crn, run, cst, lke, irq, bce;
	wire logic [1:0]  br, rr, bmode;
	wire logic [31:0] rdt, cvec;
	wire logic [23:0] eaddr;
	wire logic [7:0]  edata;
	wire rbss_memwr_t mem_wr;
	wire rbss_ldma_t [LINK_CHANNELS-1:0] preset;
	wire logic strap_w = soe ? so : strap;
	rbss_far_model #(.HOLD(60)) far_u (.clk(clk), .cs_o(so), .cs_oe(soe), .addr(eaddr), .rst_pin_n(ext_n), .data(edata));
	rbss_sequencer #(.POR_HOLD_CYCLES(50), .BOOT_WORDS(2), .IRQ_VEC_BASE(VEC)) dut_u (
		.SYS_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .EXT_RESET_N_PIN(ext_n),
		.IRQ_N_PIN(irq_n), .BOOT_SELECT_STRAP_I(strap_w), .BOOT_SELECT_STRAP_O(so), .BOOT_SELECT_STRAP_OE(soe),
		.BOOT_SRC_PINS(src), .CORE_CLOCK_RATIO_PINS(ratio), .EPROM_ADDR(eaddr), .EPROM_DATA(edata),
		.HOST_WR(host), .HOST_WR_READY(hrdy), .LINK_BLOCK_DONE(ldone), .MEM_WR(mem_wr), .LINK_DMA_PRESET(preset),
		.BOOT_MODE(bmode), .BUS_RESET_N(brn), .CORE_RESET_N(crn), .CORE_RUN(run), .CORE_START(cst),
		.CORE_VECTOR(cvec), .BUS_CLK_EN(bce), .LINK_CLK_EN(lke), .IRQ(irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [31:0] eword(input int n);
		for (int i = 0; i < 4; i++) eword[8*i +: 8] = 8'(4*n + i) ^ 8'h5A;
	endfunction : eword
	// Bus enable pulses expected in a window of 420 cycles for each ratio code.
	function automatic int bus_exp(input logic [2:0] c);
		case (c)
			3'h1: return 168;
			3'h2: return 140;
			3'h3: return 120;
			3'h4: return 105;
			3'h5: return 84;
			default: return 210;
		endcase
	endfunction : bus_exp
	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		n_tests++;
		if (got !== ex) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic final_report();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awa  <= a;
		wd   <= d;
		awv  <= 1'b1;
		wv   <= 1'b1;
		brdy <= 1'b1;
		do begin
			#1;
			ta = awv && awr;
			tw = wv && wr;
			tb = bv;
			resp = br;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		brdy <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk);
		ara  <= a;
		arv  <= 1'b1;
		rrdy <= 1'b1;
		do begin
			#1;
			ta = arv && arr;
			tr = rv;
			rd = rdt;
			resp = rr;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end while (!tr);
		rrdy <= 1'b0;
	endtask : axr
	task automatic pin(input int n);
		@(posedge clk);
		irq_n[n] <= 1'b0;
		repeat (10) @(posedge clk);
		irq_n[n] <= 1'b1;
		repeat (10) @(posedge clk);
	endtask : pin
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	always @(negedge clk) begin
		if (cst === 1'b1) starts++;
		if (lke === 1'b1) links++;
		if (bce === 1'b1) buses++;
		if (rst_n && mem_wr.valid === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
			chk("mem_wr", {e.addr, e.data}, {mem_wr.addr, mem_wr.data});
		end
	end
	initial begin
		seed = xs(seed);
		ratio <= 3'(seed % 6);
		for (int i = 0; i < 2; i++) exp_q.push_back({1'b1, 32'(i), eword(i)});
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wait (soe === 1'b1);
		chk("boot_mode", BOOT_EPROM, bmode);
		for (int i = 0; i < 4; i++) chk("preset", {LINK_DMA_BASE, 16'h0100, 1'b1}, preset[i]);
		wait (soe === 1'b0);
		axr(REG_IRQ_STAT);
		chk("irq_stat", 4'h2, rd[3:0]);
		axr(REG_STAT);
		chk("idle", 5'h04, rd[4:0]);
		chk("ratio", ratio, rd[12:10]);
		l0 = buses;
		repeat (420) @(posedge clk);
		chk("bus_rate", bus_exp(ratio), buses - l0);
		pin(2);
		chk("masked", 0, starts);
		pin(1);
		chk("vector", VEC + 4, cvec);
		chk("irq_masked", 1'b0, irq);
		axw(REG_CTRL, 32'h12);
		axr(REG_STAT);
		chk("sleep", {5'h10, 1'b0}, {rd[4:0], run});
		pin(3);
		axr(REG_STAT);
		chk("wake", {5'h08, 32'h1}, {rd[4:0], 32'(starts)});
		axw(REG_IRQ_EN, 32'h4);
		chk("bresp", RESP_OKAY, resp);
		chk("irq_on", 1'b1, irq);
		axw(REG_IRQ_CLR, 32'h4);
		chk("irq_off", 1'b0, irq);
		axw(REG_CTRL, 32'h11);
		repeat (4) @(posedge clk);
		chk("core_rst", 2'b01, {crn, brn});
		axw(REG_CTRL, 32'h20);
		l0 = links;
		repeat (21) @(posedge clk);
		chk("link_clk", 7, links - l0);
		axr(8'h40);
		chk("unmapped", RESP_SLVERR, resp);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			seed = xs(seed);
			host <= {1'b1, seed, ~seed};
			exp_q.push_back({1'b1, seed, ~seed});
			do begin
				#1;
				t = hrdy;
				@(posedge clk);
			end while (!t);
			host.valid <= 1'b0;
		end
		repeat (5) @(posedge clk);
		chk("drained", 0, exp_q.size());
		strap <= 1'b1;
		src   <= 2'h1;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wait (brn === 1'b1);
		chk("link_mode", BOOT_LINK, bmode);
		l0 = starts;
		@(posedge clk);
		ldone <= 4'h2;
		@(posedge clk);
		ldone <= 4'h0;
		repeat (3) @(posedge clk);
		chk("link_start", {32'h1, LINK_VECTOR}, {32'(starts - l0), cvec});
		axr(REG_IRQ_STAT);
		chk("short_rst", 1'b1, rd[EV_SHORT_RST]);
		final_report();
	end
endmodule : test_rbss_sequencer
